// >>> rtl/dtc_pkg.sv
// dual classic timer/counter: shared constants, field layouts and types
// assumes: 8-bit register port, one 100 MHz system clock
package dtc_pkg;

    // ------------------------------------------------------------------
    // register offsets on the plain register port
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_RUN_FLAGS = 8'h88; // run bits and flags
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h89; // timers_mode_control
    localparam logic [7:0] ADDR_T0_LOW = 8'h8a; // timer0_count_low
    localparam logic [7:0] ADDR_T1_LOW = 8'h8b; // timer1_count_low
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8c; // timer0_count_high
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8d; // timer1_count_high

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_T1_FLAG = 7; // timer1_overflow_flag, read only
    localparam int BIT_T1_RUN = 6; // timer1_run
    localparam int BIT_T0_FLAG = 5; // timer0_overflow_flag, read only
    localparam int BIT_T0_RUN = 4; // timer0_run
    localparam int POS_T1_MODE = 4; // timer 1 nibble of mode control
    localparam int POS_T0_MODE = 0; // timer 0 nibble of mode control
    localparam int PRESCALE_BITS = 5; // low byte width in mode 0

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic RST_BIT = 1'b0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    // mode select codes
    typedef enum logic [1:0] {
        DTC_MODE_13BIT = 2'h0,
        DTC_MODE_16BIT = 2'h1,
        DTC_MODE_RELOAD = 2'h2,
        DTC_MODE_SPLIT = 2'h3
    } dtc_mode_t;

    // one timer's nibble of the mode control register, msb first
    typedef struct packed {
        logic gate_enable;
        logic counter_select;
        dtc_mode_t mode;
    } dtc_tmode_t;

    // result of one counting step
    typedef struct packed {
        logic ovf;
        logic [7:0] low;
        logic [7:0] high;
    } dtc_step_t;

endpackage : dtc_pkg

// >>> rtl/dtc_pin_edge.sv
// dual classic timer/counter: falling-edge detector for a count pin
// assumes: the pin is already synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_edge (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // pin in, event out
    input wire logic i_pin,
    output logic o_fall
);

    // ------------------------------------------------------------------
    // previous pin level
    // ------------------------------------------------------------------
    logic prev_reg; // pin level one cycle ago
    logic prev_next;

    // next value is simply the pin
    always_comb begin
        prev_next = i_pin;
    end

    // starts high, so a pin already low at reset release gives one falling event
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // one-cycle pulse on a high-to-low transition
    assign o_fall = prev_reg & ~i_pin;

endmodule : dtc_pin_edge
`default_nettype wire

// >>> rtl/dtc_tick_sel.sv
// dual classic timer/counter: count-enable selection for one counter
// assumes: gate pin synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module dtc_tick_sel (
    // configuration
    input wire logic i_counter_select,
    input wire logic i_gate_enable,
    input wire logic i_run,
    // pins
    input wire logic i_gate_pin,
    input wire logic i_pin_fall,
    // result
    output logic o_tick
);

    // ------------------------------------------------------------------
    // combine run, gate and source
    // ------------------------------------------------------------------
    logic allowed; // run control after gating

    always_comb begin
        // run alone, or run and a high gate pin when gating is on
        allowed = i_run & (~i_gate_enable | i_gate_pin);
        // pin events or every system clock
        if (i_counter_select) begin
            o_tick = allowed & i_pin_fall;
        end else begin
            o_tick = allowed;
        end
    end

endmodule : dtc_tick_sel
`default_nettype wire

// >>> rtl/dtc_timer_top.sv
// dual classic timer/counter: timer 0 and timer 1 with register port
// assumes: one 100 MHz clock, pins synchronous, register master per
// the plain strobe port; interrupt entry acknowledges come from the cpu
//
// Contract
// - select bit picks external pin or clock
// - mode 0: 5-bit prescaler plus 8-bit high
// - mode 1: full 16-bit cascade
// - mode 2: low counts, reloads from high
// - two mode bits pick modes 0..3
// - mode 3 exists only for timer 0
// - mode 3: low byte uses timer 0 controls
// - mode 3: high byte takes timer 1 run/flag
// - mode 3: high byte gated by timer 1 gate
// - four count bytes read/write, reset zero
// - counting only while run bit set
// - flags cleared on interrupt routine entry
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // count and gate pins
    input wire logic i_timer0_count_pin,
    input wire logic i_timer1_count_pin,
    input wire logic i_timer0_gate_pin,
    input wire logic i_timer1_gate_pin,
    // interrupt routine entry acknowledges
    input wire logic i_timer0_int_ack,
    input wire logic i_timer1_int_ack,
    // overflow flags toward the interrupt controller
    output logic o_timer0_overflow_flag,
    output logic o_timer1_overflow_flag
);

    // ------------------------------------------------------------------
    // counting step shared by both timers
    // ------------------------------------------------------------------
    // modes 0..2 are identical for both timers; mode 3 holds here and
    // timer 0 overrides it with its split behaviour
    function automatic dtc_pkg::dtc_step_t step(
        input dtc_pkg::dtc_mode_t mode,
        input logic tick,
        input logic [7:0] low,
        input logic [7:0] high
    );
        dtc_pkg::dtc_step_t r;
        logic [5:0] pre; // prescaler with carry
        logic [8:0] sum; // byte with carry
        logic [16:0] wide; // 16-bit with carry

        r.ovf = 1'b0;
        r.low = low;
        r.high = high;

        pre = {1'b0, low[dtc_pkg::PRESCALE_BITS-1:0]} + 6'h01;
        sum = {1'b0, low} + 9'h001;
        wide = {1'b0, high, low} + 17'h00001;

        // no tick leaves every byte as it stands
        if (tick) begin
            unique case (mode)
                dtc_pkg::DTC_MODE_13BIT: begin
                    // upper three low bits are left untouched
                    r.low = {low[7:dtc_pkg::PRESCALE_BITS],
                             pre[dtc_pkg::PRESCALE_BITS-1:0]};
                    if (pre[dtc_pkg::PRESCALE_BITS]) begin
                        sum = {1'b0, high} + 9'h001;
                        r.high = sum[7:0];
                        r.ovf = sum[8];
                    end
                end

                dtc_pkg::DTC_MODE_16BIT: begin
                    r.low = wide[7:0];
                    r.high = wide[15:8];
                    r.ovf = wide[16];
                end

                dtc_pkg::DTC_MODE_RELOAD: begin
                    // reload replaces the rollover value
                    r.low = sum[8] ? high : sum[7:0];
                    r.ovf = sum[8];
                end

                dtc_pkg::DTC_MODE_SPLIT: begin
                    // timer 1 has no split mode and simply holds
                    r.ovf = 1'b0;
                end
            endcase
        end

        return r;
    endfunction : step

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] t0_low_reg, t0_low_next; // timer0_count_low
    logic [7:0] t0_high_reg, t0_high_next; // timer0_count_high
    logic [7:0] t1_low_reg, t1_low_next; // timer1_count_low
    logic [7:0] t1_high_reg, t1_high_next; // timer1_count_high
    logic [7:0] mode_ctrl_reg, mode_ctrl_next; // timers_mode_control
    logic [1:0] run_reg, run_next; // timer0_run, timer1_run
    logic [1:0] flag_reg, flag_next; // overflow flags
    logic [7:0] rdata_reg, rdata_next; // read data, one cycle late

    // ------------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------------
    dtc_pkg::dtc_tmode_t t0_cfg; // timer 0 nibble
    dtc_pkg::dtc_tmode_t t1_cfg; // timer 1 nibble
    logic split; // timer 0 in mode 3
    logic [1:0] pin_fall; // count pin events
    logic [1:0] tick; // per-timer count enables
    logic high_tick; // split high byte enable
    logic [1:0] ack; // interrupt entry acknowledges

    assign t0_cfg = dtc_pkg::dtc_tmode_t'(
        mode_ctrl_reg[dtc_pkg::POS_T0_MODE +: 4]);
    assign t1_cfg = dtc_pkg::dtc_tmode_t'(
        mode_ctrl_reg[dtc_pkg::POS_T1_MODE +: 4]);
    assign split = (t0_cfg.mode == dtc_pkg::DTC_MODE_SPLIT);

    assign ack = {i_timer1_int_ack, i_timer0_int_ack};

    // ------------------------------------------------------------------
    // pin edges and count enables
    // ------------------------------------------------------------------
    logic [1:0] count_pin; // external count pins
    logic [1:0] gate_pin; // external gate pins
    logic [1:0] cfg_cs; // counter-select per timer
    logic [1:0] cfg_gate; // gate enable per timer

    assign count_pin = {i_timer1_count_pin, i_timer0_count_pin};
    assign gate_pin = {i_timer1_gate_pin, i_timer0_gate_pin};
    assign cfg_cs = {t1_cfg.counter_select, t0_cfg.counter_select};
    assign cfg_gate = {t1_cfg.gate_enable, t0_cfg.gate_enable};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_timer
            // one edge detector and one enable per timer
            dtc_pin_edge u_edge (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_pin(count_pin[g]),
                .o_fall(pin_fall[g])
            );

            dtc_tick_sel u_tick (
                .i_counter_select(cfg_cs[g]),
                .i_gate_enable(cfg_gate[g]),
                .i_run(run_reg[g]),
                .i_gate_pin(gate_pin[g]),
                .i_pin_fall(pin_fall[g]),
                .o_tick(tick[g])
            );
        end
    endgenerate

    // split high byte: internal clock only, timer 1 run and gate
    dtc_tick_sel u_high_tick (
        .i_counter_select(1'b0),
        .i_gate_enable(t1_cfg.gate_enable),
        .i_run(run_reg[1]),
        .i_gate_pin(i_timer1_gate_pin),
        .i_pin_fall(1'b0),
        .o_tick(high_tick)
    );

    // ------------------------------------------------------------------
    // counters, control and flags: next values
    // ------------------------------------------------------------------
    dtc_pkg::dtc_step_t s0; // timer 0 step, modes 0..2
    dtc_pkg::dtc_step_t s1; // timer 1 step
    logic [8:0] sp_low; // split low byte with carry
    logic [8:0] sp_high; // split high byte with carry
    logic [1:0] ovf; // overflow events this cycle

    always_comb begin
        s0 = step(t0_cfg.mode, tick[0], t0_low_reg, t0_high_reg);
        s1 = step(t1_cfg.mode, tick[1], t1_low_reg, t1_high_reg);

        sp_low = {1'b0, t0_low_reg} + 9'h001;
        sp_high = {1'b0, t0_high_reg} + 9'h001;

        // modes 0..2 come straight from the step
        t0_low_next = s0.low;
        t0_high_next = s0.high;
        t1_low_next = s1.low;
        t1_high_next = s1.high;

        // control bits hold unless written
        mode_ctrl_next = mode_ctrl_reg;
        run_next = run_reg;
        ovf = {s1.ovf, s0.ovf};

        if (split) begin
            // two independent 8-bit counters
            t0_low_next = tick[0] ? sp_low[7:0] : t0_low_reg;
            t0_high_next = high_tick ? sp_high[7:0] : t0_high_reg;
            ovf[0] = tick[0] & sp_low[8];

            // high byte owns timer 1's flag; timer 1's own is dropped
            ovf[1] = high_tick & sp_high[8];
        end

        // software writes win over counting in the same cycle
        if (i_wr) begin
            unique case (i_addr)
                dtc_pkg::ADDR_T0_LOW: t0_low_next = i_wdata;
                dtc_pkg::ADDR_T0_HIGH: t0_high_next = i_wdata;
                dtc_pkg::ADDR_T1_LOW: t1_low_next = i_wdata;
                dtc_pkg::ADDR_T1_HIGH: t1_high_next = i_wdata;
                dtc_pkg::ADDR_MODE_CTRL: mode_ctrl_next = i_wdata;
                dtc_pkg::ADDR_RUN_FLAGS: begin
                    // flags are not writable; only run bits land
                    run_next = {i_wdata[dtc_pkg::BIT_T1_RUN],
                                i_wdata[dtc_pkg::BIT_T0_RUN]};
                end

                default: begin
                    // unmapped write is ignored
                end
            endcase
        end

        // a new overflow beats an acknowledge in the same cycle
        flag_next = (flag_reg & ~ack) | ovf;
    end

    // ------------------------------------------------------------------
    // read path: next value
    // ------------------------------------------------------------------
    // data stand for exactly the cycle after the strobe, zero otherwise
    always_comb begin
        rdata_next = 8'h00;

        // only a strobe loads real data
        if (i_rd) begin
            unique case (i_addr)
                dtc_pkg::ADDR_T0_LOW: rdata_next = t0_low_reg;
                dtc_pkg::ADDR_T0_HIGH: rdata_next = t0_high_reg;
                dtc_pkg::ADDR_T1_LOW: rdata_next = t1_low_reg;
                dtc_pkg::ADDR_T1_HIGH: rdata_next = t1_high_reg;
                dtc_pkg::ADDR_MODE_CTRL: rdata_next = mode_ctrl_reg;
                dtc_pkg::ADDR_RUN_FLAGS: begin
                    rdata_next[dtc_pkg::BIT_T1_FLAG] = flag_reg[1];
                    rdata_next[dtc_pkg::BIT_T1_RUN] = run_reg[1];
                    rdata_next[dtc_pkg::BIT_T0_FLAG] = flag_reg[0];
                    rdata_next[dtc_pkg::BIT_T0_RUN] = run_reg[0];
                end

                default: rdata_next = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            // everything clears to zero
            t0_low_reg <= dtc_pkg::RST_COUNT;
            t0_high_reg <= dtc_pkg::RST_COUNT;
            t1_low_reg <= dtc_pkg::RST_COUNT;
            t1_high_reg <= dtc_pkg::RST_COUNT;
            mode_ctrl_reg <= dtc_pkg::RST_MODE;
            run_reg <= {2{dtc_pkg::RST_BIT}};
            flag_reg <= {2{dtc_pkg::RST_BIT}};
            rdata_reg <= dtc_pkg::RST_COUNT;
        end else begin
            t0_low_reg <= t0_low_next;
            t0_high_reg <= t0_high_next;
            t1_low_reg <= t1_low_next;
            t1_high_reg <= t1_high_next;
            mode_ctrl_reg <= mode_ctrl_next;
            run_reg <= run_next;
            flag_reg <= flag_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // outputs come straight from flip-flops
    assign o_rdata = rdata_reg;
    assign o_timer0_overflow_flag = flag_reg[0];
    assign o_timer1_overflow_flag = flag_reg[1];

endmodule : dtc_timer_top
`default_nettype wire

// >>> bench/dtc_timer_assertions.sv
// dual timer/counter: port-level assertions for dtc_timer_top
// assumes: bound to the top module, one clock domain, async reset
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_assertions (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // pins and flags
    input wire logic i_timer0_gate_pin,
    input wire logic i_timer1_gate_pin,
    input wire logic i_timer0_int_ack,
    input wire logic i_timer1_int_ack,
    input wire logic o_timer0_overflow_flag,
    input wire logic o_timer1_overflow_flag
);
    // ------------------------------------------------------------------
    // shadow of what software wrote
    // ------------------------------------------------------------------
    logic rd_reg; // read strobe one cycle ago
    logic rd_next;
    logic [7:0] mode_reg; // mirror of the mode control byte
    logic [7:0] mode_next;
    logic run0_reg; // mirror of the run bits
    logic run0_next;
    logic run1_reg;
    logic run1_next;
    // next values follow writes on the register port
    always_comb begin
        rd_next = i_rd;
        mode_next = mode_reg;
        run0_next = run0_reg;
        run1_next = run1_reg;
        if (i_wr && i_addr == dtc_pkg::ADDR_MODE_CTRL) begin
            mode_next = i_wdata;
        end
        if (i_wr && i_addr == dtc_pkg::ADDR_RUN_FLAGS) begin
            run0_next = i_wdata[dtc_pkg::BIT_T0_RUN];
            run1_next = i_wdata[dtc_pkg::BIT_T1_RUN];
        end
    end
    // same async reset as the block, so mirrors never go stale
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_reg <= 1'b0;
            mode_reg <= 8'h00;
            run0_reg <= 1'b0;
            run1_reg <= 1'b0;
        end else begin
            rd_reg <= rd_next;
            mode_reg <= mode_next;
            run0_reg <= run0_next;
            run1_reg <= run1_next;
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_rd_mode;
        i_rd && i_addr == dtc_pkg::ADDR_MODE_CTRL;
    endsequence
    sequence s_rd_status;
        i_rd && i_addr == dtc_pkg::ADDR_RUN_FLAGS;
    endsequence
    sequence s_rd_hole;
        i_rd && (i_addr < 8'h88 || i_addr > 8'h8d);
    endsequence
    a_rdata_idle:
        assert property (!rd_reg |-> o_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_mode_readback:
        assert property (s_rd_mode |=> o_rdata == mode_reg)
        else $error("mode byte read back wrong");
    a_status_readback:
        assert property (s_rd_status |=> o_rdata ==
            {$past(o_timer1_overflow_flag), $past(run1_reg),
            $past(o_timer0_overflow_flag), $past(run0_reg), 4'h0})
        else $error("run and flag byte read back wrong");
    a_hole_reads_zero:
        assert property (s_rd_hole |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_flag0_sticky:
        assert property (o_timer0_overflow_flag && !i_timer0_int_ack
            |=> o_timer0_overflow_flag) else $error("flag0 dropped");
    a_flag1_sticky:
        assert property (o_timer1_overflow_flag && !i_timer1_int_ack
            |=> o_timer1_overflow_flag) else $error("flag1 dropped");
    a_flag0_cleared:
        assert property (i_timer0_int_ack && !run0_reg
            |=> !o_timer0_overflow_flag) else $error("flag0 not cleared");
    a_flag1_cleared:
        assert property (i_timer1_int_ack && !run1_reg
            |=> !o_timer1_overflow_flag) else $error("flag1 not cleared");
    a_flag0_run_gate:
        assert property ($rose(o_timer0_overflow_flag) |-> $past(run0_reg)
            && (!$past(mode_reg[3]) || $past(i_timer0_gate_pin)))
        else $error("flag0 set while stopped or gated");
    a_flag1_run_gate:
        assert property ($rose(o_timer1_overflow_flag) |-> $past(run1_reg)
            && (!$past(mode_reg[7]) || $past(i_timer1_gate_pin)))
        else $error("flag1 set while stopped or gated");
endmodule : dtc_timer_assertions
`default_nettype wire

// >>> bench/dtc_pin_model.sv
// dual timer/counter: model of the external count pins
// assumes: bench requests one falling edge per pulse on i_fire
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
    // clock
    input wire logic i_clk_sys,
    // requests from the bench
    input wire logic [1:0] i_fire,
    input wire logic i_slow,
    // count pins, idle high as with a pull-up
    output logic [1:0] o_pins
);
    int unsigned low_left [2]; // cycles each pin still stays low
    // slow pulses stay low longer, the edge count must not change
    always @(posedge i_clk_sys) begin
        for (int k = 0; k < 2; k++) begin
            if (i_fire[k]) begin
                o_pins[k] <= 1'b0;
                low_left[k] <= i_slow ? 3 : 1;
            end else if (low_left[k] > 1) begin
                low_left[k] <= low_left[k] - 1;
            end else begin
                o_pins[k] <= 1'b1;
                low_left[k] <= 0;
            end
        end
    end
endmodule : dtc_pin_model
`default_nettype wire

// >>> bench/dual_classic_timer_counter_tb_top.sv
// dual timer/counter: self-checking testbench
// assumes: 100 MHz clock, counts stepped by exact run windows
`timescale 1ns/1ps
`default_nettype none
module dual_classic_timer_counter_tb_top;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] o_rdata;
    logic [1:0] fire = 2'h0; // pulse requests to the pin model
    logic slow = 1'b0;
    logic [1:0] gate = 2'h0; // gate pins, [1] timer1
    logic [1:0] ack = 2'h0; // interrupt entry acknowledges
    logic [1:0] pins;
    logic o_timer0_overflow_flag;
    logic o_timer1_overflow_flag;
    int n_errors = 0;
    int n_checks = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    dtc_pin_model i_pins (.i_clk_sys, .i_fire(fire), .i_slow(slow),
        .o_pins(pins));
    dtc_timer_top i_dut (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_timer0_count_pin(pins[0]),
        .i_timer1_count_pin(pins[1]), .i_timer0_gate_pin(gate[0]),
        .i_timer1_gate_pin(gate[1]), .i_timer0_int_ack(ack[0]),
        .i_timer1_int_ack(ack[1]), .o_timer0_overflow_flag,
        .o_timer1_overflow_flag);
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // every edge assigns all strobes once, so calls chain with no gap
    task automatic drive(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] d, input logic [1:0] f, input logic [1:0] k);
        @(posedge i_clk_sys);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        fire <= f;
        ack <= k;
    endtask : drive
    task automatic idle(input int n);
        repeat (n) drive(1'b0, 1'b0, 8'h00, 8'h00, 2'h0, 2'h0);
    endtask : idle
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        drive(1'b1, 1'b0, a, d, 2'h0, 2'h0);
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        drive(1'b0, 1'b1, a, 8'h00, 2'h0, 2'h0);
        idle(1);
        #1;
        chk($sformatf("reg %h", a), o_rdata, exp);
    endtask : rchk
    task automatic fchk(input logic [7:0] exp);
        #1;
        chk("flags", {6'h00, o_timer1_overflow_flag,
            o_timer0_overflow_flag}, exp);
    endtask : fchk
    task automatic pulse(input logic [1:0] k);
        drive(1'b0, 1'b0, 8'h00, 8'h00, k, 2'h0);
        idle(4);
    endtask : pulse
    task automatic clear(input logic [1:0] k);
        drive(1'b0, 1'b0, 8'h00, 8'h00, 2'h0, k);
        idle(1);
    endtask : clear
    // run bits on for exactly n counting edges, then off
    task automatic run(input logic [7:0] v, input int n);
        wreg(8'h88, v);
        idle(n - 1);
        wreg(8'h88, 8'h00);
    endtask : run
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        #1000000;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        for (logic [7:0] a = 8'h87; a < 8'h8f; a++) rchk(a, 8'h00);
        for (logic [7:0] a = 8'h8a; a < 8'h8e; a++) wreg(a, a ^ 8'h3c);
        for (logic [7:0] a = 8'h8a; a < 8'h8e; a++)
            rchk(a, a ^ 8'h3c);
        wreg(8'h89, 8'ha5);
        rchk(8'h89, 8'ha5);
        wreg(8'h88, 8'hff);
        rchk(8'h88, 8'h50);
        wreg(8'h88, 8'h00);
        wreg(8'h89, 8'h01);
        wreg(8'h8c, 8'hff);
        wreg(8'h8a, 8'hfe);
        run(8'h10, 2);
        rchk(8'h8a, 8'h00);
        rchk(8'h8c, 8'h00);
        fchk(8'h01);
        clear(2'h1);
        fchk(8'h00);
        wreg(8'h89, 8'h00);
        wreg(8'h8c, 8'h12);
        wreg(8'h8a, 8'hff);
        run(8'h10, 1);
        rchk(8'h8a, 8'he0);
        rchk(8'h8c, 8'h13);
        fchk(8'h00);
        wreg(8'h8c, 8'hff);
        wreg(8'h8a, 8'h1f);
        run(8'h10, 1);
        rchk(8'h8c, 8'h00);
        fchk(8'h01);
        clear(2'h1);
        wreg(8'h89, 8'h02);
        wreg(8'h8c, 8'h80);
        wreg(8'h8a, 8'hff);
        run(8'h10, 1);
        rchk(8'h8a, 8'h80);
        fchk(8'h01);
        clear(2'h1);
        run(8'h10, 3);
        rchk(8'h8a, 8'h83);
        rchk(8'h8c, 8'h80);
        wreg(8'h89, 8'h55);
        wreg(8'h8a, 8'h00);
        wreg(8'h8b, 8'h00);
        wreg(8'h88, 8'h50);
        idle(3);
        pulse(2'h3);
        slow <= 1'b1;
        pulse(2'h3);
        slow <= 1'b0;
        pulse(2'h1);
        wreg(8'h88, 8'h00);
        rchk(8'h8a, 8'h03);
        rchk(8'h8b, 8'h02);
        wreg(8'h89, 8'h09);
        wreg(8'h8a, 8'h00);
        run(8'h10, 5);
        rchk(8'h8a, 8'h00);
        @(posedge i_clk_sys) gate <= 2'h1;
        run(8'h10, 5);
        rchk(8'h8a, 8'h05);
        @(posedge i_clk_sys) gate <= 2'h0;
        wreg(8'h89, 8'h10);
        wreg(8'h8d, 8'hff);
        wreg(8'h8b, 8'hff);
        run(8'h40, 1);
        rchk(8'h8b, 8'h00);
        fchk(8'h02);
        clear(2'h2);
        fchk(8'h00);
        wreg(8'h89, 8'h30);
        wreg(8'h8b, 8'h05);
        run(8'h40, 4);
        rchk(8'h8b, 8'h05);
        wreg(8'h89, 8'h83);
        wreg(8'h8a, 8'hfe);
        wreg(8'h8c, 8'hfe);
        run(8'h50, 2);
        rchk(8'h8a, 8'h00);
        rchk(8'h8c, 8'hfe);
        fchk(8'h01);
        clear(2'h1);
        gate <= 2'h2;
        run(8'h40, 2);
        rchk(8'h8c, 8'h00);
        rchk(8'h8a, 8'h00);
        rchk(8'h8b, 8'h07);
        fchk(8'h02);
        clear(2'h2);
        i_rst <= 1'b1;
        idle(2);
        i_rst <= 1'b0;
        rchk(8'h8d, 8'h00);
        rchk(8'h89, 8'h00);
        end_of_test();
    end
endmodule : dual_classic_timer_counter_tb_top
bind dtc_timer_top dtc_timer_assertions i_chk (.i_clk_sys, .i_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_timer0_gate_pin,
    .i_timer1_gate_pin, .i_timer0_int_ack, .i_timer1_int_ack,
    .o_timer0_overflow_flag, .o_timer1_overflow_flag);
`default_nettype wire
